// file: common/sbet_pkg.sv
// Register map, field layout and encodings of the sixteen-bit event timer.
package sbet_pkg;

	// Register byte addresses on the bus.
	localparam logic [7:0] ADDR_CONTROL_A = 8'h00;
	localparam logic [7:0] ADDR_CONTROL_B = 8'h04;
	localparam logic [7:0] ADDR_EVENT_CTL = 8'h08;
	localparam logic [7:0] ADDR_FLAGS     = 8'h0c;
	localparam logic [7:0] ADDR_STATUS    = 8'h10;
	localparam logic [7:0] ADDR_COUNT     = 8'h14;
	localparam logic [7:0] ADDR_COMPARE   = 8'h18;

	// Field positions.
	localparam int EN_BIT      = 0;
	localparam int SRC_LSB     = 1;
	localparam int MODE_LSB    = 0;
	localparam int PIN_EN_BIT  = 4;
	localparam int PIN_INI_BIT = 5;
	localparam int EDGE_BIT    = 4;
	localparam int FCAP_BIT    = 0;
	localparam int FOVR_BIT    = 1;
	localparam int RUN_BIT     = 0;

	// Operating modes.
	localparam logic [2:0] MODE_PERIODIC = 3'h0;
	localparam logic [2:0] MODE_TIMEOUT  = 3'h1;
	localparam logic [2:0] MODE_CAP_EV   = 3'h2;
	localparam logic [2:0] MODE_FREQ     = 3'h3;
	localparam logic [2:0] MODE_PWIDTH   = 3'h4;
	localparam logic [2:0] MODE_FRQPW    = 3'h5;
	localparam logic [2:0] MODE_SINGLE   = 3'h6;
	localparam logic [2:0] MODE_PWM8     = 3'h7;

	// Counter clock sources.
	localparam logic [1:0] SRC_DIV1      = 2'h0;
	localparam logic [1:0] SRC_DIV2      = 2'h1;
	localparam logic [1:0] SRC_COMPANION = 2'h2;
	localparam logic [1:0] SRC_EVENT     = 2'h3;

	// Values after reset.
	localparam logic [2:0]  MODE_RST    = MODE_PERIODIC;
	localparam logic [1:0]  SRC_RST     = SRC_DIV1;
	localparam logic [15:0] COUNT_RST   = 16'h0000;
	localparam logic [15:0] COMPARE_RST = 16'h0000;

	// Run state of the time-out check.
	typedef enum logic [1:0] {
		RUN_IDLE   = 2'b01,
		RUN_ACTIVE = 2'b10
	} sbet_run_e;

endpackage : sbet_pkg

// file: design/sbet_top.sv
// Sixteen-bit event timer with an AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Counter clock comes from divided system clock, companion timer or event input.
// - Companion timer source advances the counter on the companion's own ticks.
// - Counter is sixteen bits; bottom zero, maximum all ones, top is compare.
// - Eight mode codes are selectable in control register b; all codes but time-out and capture run as periodic.
// - Reset leaves the block in periodic interrupt mode.
// - Pin enable puts the waveform on the pin instead of port data.
// - Enable starts counting on the chosen clock, in time-out mode only from the start edge; count is readable.
// - Reaching top sets capture flag and pulses the capture event.
// - Top below count: run to maximum, flag overflow, wrap to zero.
// - Periodic mode counts up to the compare value then restarts.
// - Time-out check starts on one edge, freezes on the next.
// - Time-out start and stop polarity follows the edge select bit.
// - Time-out reaching top before stop sets capture flag and event.
// - Frozen reads of count or compare, and run writes, change nothing.
// - Input capture mode counts freely zero to maximum and wraps.
// - Each capture edge copies count to compare and raises capture.
// - Capture edge detector responds to rising or falling edges.
// - In capture mode reading compare clears the capture flag.
// - Capture mode flags overflow and pulses event at maximum count.
module sbet_top #(
	parameter int CNT_W = 16
) (
	// Clock and reset.
	input  wire logic        CLK_IN,
	input  wire logic        NRST_IN,
	// AHB-Lite slave.
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	// Clock and event sources.
	input  wire logic        COMP_TICK_IN,
	input  wire logic        EVENT_IN,
	// Pin and events out.
	input  wire logic        PORT_OUT_IN,
	output logic             PIN_OUT,
	output logic             CAPTURE_EVENT_OUT,
	output logic             OVERFLOW_EVENT_OUT
);

	localparam logic [CNT_W-1:0] MAXV = '1;

	// Only widths the bus word can carry are served.
	if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
		$error("CNT_W must be 2 to 32");
	end

	logic [7:0]       addr_q;
	logic             wr_pend_q;
	logic             rd_wait_q;
	logic [31:0]      rdata_q;
	logic             en_q;
	logic [1:0]       src_q;
	logic [2:0]       mode_q;
	logic             pin_en_q;
	logic             pin_ini_q;
	logic             edge_q;
	logic             cap_flag_q;
	logic             ovr_flag_q;
	logic [CNT_W-1:0] cv_q;
	logic [CNT_W-1:0] ccv_q;
	logic             div_q;
	logic             ev_s1_q;
	logic             ev_s2_q;
	logic             ev_s3_q;
	logic             wave_q;
	logic             cap_ev_q;
	logic             ovr_ev_q;
	sbet_pkg::sbet_run_e run_q;

	logic acc;
	logic acc_rd;
	logic wr_a;
	logic wr_b;
	logic wr_ev;
	logic wr_fl;
	logic wr_cv;
	logic wr_ccv;
	logic ev_rise;
	logic ev_fall;
	logic edge_hit;
	logic tick;
	logic is_to;
	logic is_cap;
	logic counting;
	logic start;
	logic top_hit;
	logic max_hit;
	logic cap_hit;
	logic rd_clr;
	logic running;

	// A transfer is taken when selected, non-idle and the bus is ready.
	assign acc    = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
	assign acc_rd = acc & ~HWRITE_IN;

	// Writes land in the data phase, which never waits.
	assign wr_a   = wr_pend_q && addr_q == sbet_pkg::ADDR_CONTROL_A;
	assign wr_b   = wr_pend_q && addr_q == sbet_pkg::ADDR_CONTROL_B;
	assign wr_ev  = wr_pend_q && addr_q == sbet_pkg::ADDR_EVENT_CTL;
	assign wr_fl  = wr_pend_q && addr_q == sbet_pkg::ADDR_FLAGS;
	assign wr_cv  = wr_pend_q && addr_q == sbet_pkg::ADDR_COUNT;
	assign wr_ccv = wr_pend_q && addr_q == sbet_pkg::ADDR_COMPARE;

	// Address phase capture; a read adds one wait so it sees settled registers.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			addr_q    <= 8'h00;
			wr_pend_q <= 1'b0;
			rd_wait_q <= 1'b0;
		end else begin
			if (acc) begin
				addr_q <= HADDR_IN[7:0];
			end
			wr_pend_q <= acc & HWRITE_IN;
			rd_wait_q <= acc_rd;
		end
	end

	assign HREADYOUT_OUT = ~rd_wait_q;
	assign HRESP_OUT     = 1'b0;
	assign HRDATA_OUT    = rdata_q;

	// Read data is loaded during the wait cycle; unmapped words read zero.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_wait_q) begin
			rdata_q <= 32'h0000_0000;
			case (addr_q)
				sbet_pkg::ADDR_CONTROL_A: begin
					rdata_q[sbet_pkg::EN_BIT]                   <= en_q;
					rdata_q[sbet_pkg::SRC_LSB +: 2]             <= src_q;
				end
				sbet_pkg::ADDR_CONTROL_B: begin
					rdata_q[sbet_pkg::MODE_LSB +: 3]            <= mode_q;
					rdata_q[sbet_pkg::PIN_EN_BIT]               <= pin_en_q;
					rdata_q[sbet_pkg::PIN_INI_BIT]              <= pin_ini_q;
				end
				sbet_pkg::ADDR_EVENT_CTL: rdata_q[sbet_pkg::EDGE_BIT] <= edge_q;
				sbet_pkg::ADDR_FLAGS: begin
					rdata_q[sbet_pkg::FCAP_BIT]                 <= cap_flag_q;
					rdata_q[sbet_pkg::FOVR_BIT]                 <= ovr_flag_q;
				end
				sbet_pkg::ADDR_STATUS:  rdata_q[sbet_pkg::RUN_BIT] <= running;
				sbet_pkg::ADDR_COUNT:   rdata_q[CNT_W-1:0] <= cv_q;
				sbet_pkg::ADDR_COMPARE: rdata_q[CNT_W-1:0] <= ccv_q;
				default:                rdata_q <= 32'h0000_0000;
			endcase
		end
	end

	// Control fields; the mode resets to periodic interrupt.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			en_q      <= 1'b0;
			src_q     <= sbet_pkg::SRC_RST;
			mode_q    <= sbet_pkg::MODE_RST;
			pin_en_q  <= 1'b0;
			pin_ini_q <= 1'b0;
			edge_q    <= 1'b0;
		end else begin
			if (wr_a) begin
				en_q  <= HWDATA_IN[sbet_pkg::EN_BIT];
				src_q <= HWDATA_IN[sbet_pkg::SRC_LSB +: 2];
			end
			if (wr_b) begin
				mode_q    <= HWDATA_IN[sbet_pkg::MODE_LSB +: 3];
				pin_en_q  <= HWDATA_IN[sbet_pkg::PIN_EN_BIT];
				pin_ini_q <= HWDATA_IN[sbet_pkg::PIN_INI_BIT];
			end
			if (wr_ev) begin
				edge_q <= HWDATA_IN[sbet_pkg::EDGE_BIT];
			end
		end
	end

	// The event line comes from another block; two stages before any use.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ev_s1_q <= 1'b0;
			ev_s2_q <= 1'b0;
			ev_s3_q <= 1'b0;
		end else begin
			ev_s1_q <= EVENT_IN;
			ev_s2_q <= ev_s1_q;
			ev_s3_q <= ev_s2_q;
		end
	end

	// Pulses shorter than one clock may slip through the stages unseen.
	assign ev_rise  = ev_s2_q & ~ev_s3_q;
	assign ev_fall  = ~ev_s2_q & ev_s3_q;
	assign edge_hit = edge_q ? ev_fall : ev_rise;

	// Divide-by-two prescaler tap.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end

	// Counter clock selection.
	always_comb begin
		case (src_q)
			sbet_pkg::SRC_DIV1:      tick = 1'b1;
			sbet_pkg::SRC_DIV2:      tick = div_q;
			sbet_pkg::SRC_COMPANION: tick = COMP_TICK_IN;
			sbet_pkg::SRC_EVENT:     tick = ev_rise;
			default:                 tick = 1'b0;
		endcase
	end

	assign is_to  = mode_q == sbet_pkg::MODE_TIMEOUT;
	assign is_cap = mode_q == sbet_pkg::MODE_CAP_EV;

	// Time-out check run state: a start edge arms, the next edge freezes.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			run_q <= sbet_pkg::RUN_IDLE;
		end else if (!en_q || !is_to) begin
			run_q <= sbet_pkg::RUN_IDLE;
		end else if (edge_hit) begin
			case (run_q)
				sbet_pkg::RUN_IDLE:   run_q <= sbet_pkg::RUN_ACTIVE;
				sbet_pkg::RUN_ACTIVE: run_q <= sbet_pkg::RUN_IDLE;
				default:              run_q <= sbet_pkg::RUN_IDLE;
			endcase
		end
	end

	assign running  = en_q & (~is_to | (run_q == sbet_pkg::RUN_ACTIVE));
	assign counting = running & tick;
	assign start    = en_q & is_to & (run_q == sbet_pkg::RUN_IDLE) & edge_hit;
	assign top_hit  = counting & ~is_cap & (cv_q == ccv_q);
	assign max_hit  = counting & (cv_q == MAXV);
	assign cap_hit  = en_q & is_cap & edge_hit;
	// Reading compare in capture mode counts as reading its low byte.
	assign rd_clr   = rd_wait_q & is_cap & addr_q == sbet_pkg::ADDR_COMPARE;

	// Counter; a bus write wins over counting and restart.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cv_q <= CNT_W'(sbet_pkg::COUNT_RST);
		end else if (wr_cv) begin
			cv_q <= HWDATA_IN[CNT_W-1:0];
		end else if (start) begin
			cv_q <= '0;
		end else if (counting) begin
			if (cv_q == MAXV) begin
				cv_q <= '0;
			end else if (top_hit && !is_to) begin
				cv_q <= '0;
			end else begin
				cv_q <= cv_q + 1'b1;
			end
		end
	end

	// Compare value; a capture copies the live count.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			ccv_q <= CNT_W'(sbet_pkg::COMPARE_RST);
		end else if (wr_ccv) begin
			ccv_q <= HWDATA_IN[CNT_W-1:0];
		end else if (cap_hit) begin
			ccv_q <= cv_q;
		end
	end

	// Sticky flags: hardware set wins over a write-one or read clear.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cap_flag_q <= 1'b0;
			ovr_flag_q <= 1'b0;
		end else begin
			if (top_hit || cap_hit) begin
				cap_flag_q <= 1'b1;
			end else if ((wr_fl && HWDATA_IN[sbet_pkg::FCAP_BIT]) || rd_clr) begin
				cap_flag_q <= 1'b0;
			end
			if (max_hit) begin
				ovr_flag_q <= 1'b1;
			end else if (wr_fl && HWDATA_IN[sbet_pkg::FOVR_BIT]) begin
				ovr_flag_q <= 1'b0;
			end
		end
	end

	// Event outputs are one-cycle registered pulses.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cap_ev_q <= 1'b0;
			ovr_ev_q <= 1'b0;
		end else begin
			cap_ev_q <= top_hit | cap_hit;
			ovr_ev_q <= max_hit;
		end
	end

	assign CAPTURE_EVENT_OUT  = cap_ev_q;
	assign OVERFLOW_EVENT_OUT = ovr_ev_q;

	// Waveform starts at its initial level and toggles on each top match.
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			wave_q <= 1'b0;
		end else if (!en_q) begin
			wave_q <= pin_ini_q;
		end else if (top_hit) begin
			wave_q <= ~wave_q;
		end
	end

	// Pin enable overrides the port data register.
	assign PIN_OUT = pin_en_q ? wave_q : PORT_OUT_IN;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);

	sequence s_cmp_read;
		acc_rd && HADDR_IN[7:0] == sbet_pkg::ADDR_COMPARE && is_cap;
	endsequence

	sequence s_no_set;
		!top_hit && !cap_hit;
	endsequence

	property p_read_clear;
		s_cmp_read ##1 (s_no_set and is_cap) |=> !cap_flag_q;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read left flag set");

	property p_periodic_wrap;
		counting && !is_to && !is_cap && cv_q == ccv_q && !wr_cv |=> cv_q == '0;
	endproperty
	a_periodic_wrap: assert property (p_periodic_wrap) else $error("no wrap at top");

	property p_top_flag;
		top_hit |=> cap_flag_q && cap_ev_q ##1 (!cap_ev_q || $past(top_hit || cap_hit));
	endproperty
	a_top_flag: assert property (p_top_flag) else $error("top match not flagged");

	property p_max_wrap;
		max_hit && !wr_cv |=> ovr_flag_q && ovr_ev_q && cv_q == '0;
	endproperty
	a_max_wrap: assert property (p_max_wrap) else $error("max not handled");

	property p_step;
		counting && cv_q != MAXV && !top_hit && !wr_cv && !start
			|=> cv_q == $past(cv_q) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");

	property p_idle_hold;
		!en_q && !wr_cv |=> $stable(cv_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("count moved while off");

	property p_capture;
		cap_hit && !wr_ccv |=> ccv_q == $past(cv_q) && cap_flag_q;
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost");

	property p_freeze;
		is_to && run_q == sbet_pkg::RUN_IDLE && !start && !wr_cv && !wr_b
			|=> $stable(cv_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("frozen count moved");

	property p_pin;
		pin_en_q ? PIN_OUT == wave_q : PIN_OUT == PORT_OUT_IN;
	endproperty
	a_pin: assert property (p_pin) else $error("pin mux wrong");

	property p_read_wait;
		acc_rd |=> !HREADYOUT_OUT ##1 HREADYOUT_OUT;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read timing wrong");

endmodule : sbet_top

`default_nettype wire

// file: tb/sbet_fabric_model.sv
// Behavioural model of the event fabric, companion timer tick and port output latch.
`timescale 1ns/1ps
`default_nettype none
module sbet_fabric_model (
	// Clock.
	input  wire logic clk_in,
	// Driven lines.
	output logic      event_out,
	output logic      tick_out,
	output logic      port_out
);
	// Lines start quiet so the timer sees no edge out of reset.
	initial begin
		event_out = 1'b0;
		tick_out  = 1'b0;
		port_out  = 1'b0;
	end

	// Each event level stands at least four cycles, more than the synchroniser needs.
	task automatic level(input logic v);
		@(posedge clk_in);
		event_out <= v;
		repeat (3) @(posedge clk_in);
	endtask : level

	// Companion ticks are one-cycle pulses with a quiet cycle between them.
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk_in);
			tick_out <= 1'b1;
			@(posedge clk_in);
			tick_out <= 1'b0;
		end
	endtask : ticks

	// Port output register value, changed just after an edge.
	task automatic set_port(input logic v);
		@(posedge clk_in);
		port_out <= v;
	endtask : set_port
endmodule : sbet_fabric_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking testbench of the sixteen-bit event timer.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk, nrst, hsel, hwrite, hready, hresp, pin, cap_ev, ovf_ev, ev, tk, port;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] exp_q[$];
	logic        rd_pend;
	int          n_mismatch, num_checks, cyc, n_cap, n_ovf;
	int unsigned n;

	sbet_top sbet_top_i (.CLK_IN(clk), .NRST_IN(nrst), .HSEL_IN(hsel), .HADDR_IN(haddr),
		.HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
		.COMP_TICK_IN(tk), .EVENT_IN(ev), .PORT_OUT_IN(port), .PIN_OUT(pin),
		.CAPTURE_EVENT_OUT(cap_ev), .OVERFLOW_EVENT_OUT(ovf_ev));
	sbet_fabric_model sbet_fabric_model_i (.clk_in(clk), .event_out(ev), .tick_out(tk),
		.port_out(port));

	// Clock at 100 MHz.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Ends the run with the verdict; also reached by the hang limit.
	task automatic print_verdict();
		if (n_mismatch == 0 && num_checks > 0 && exp_q.size() == 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single AHB-Lite transfer; every wait ends only on hready or the hang limit.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'($urandom), a};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	// The expected word is noted first; the monitor compares when the data arrives.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, $urandom);
	endtask : rd

	// Control A word from a clock source and the enable bit.
	function automatic logic [31:0] ca(input logic [1:0] s);
		return {29'h0, s, 1'b1};
	endfunction : ca

	// Watches read data phases and takes the oldest note at each completion.
	always @(posedge clk) begin
		if (rd_pend && hready === 1'b1) begin
			rd_pend = 1'b0;
			chk(hresp, 1'b0);
			if (exp_q.size() == 0) begin
				chk(hrdata, 32'hxxxxxxxx);
			end else begin
				chk(hrdata, exp_q.pop_front());
			end
		end
		if (hsel && htrans[1] && !hwrite && hready === 1'b1) begin
			rd_pend = 1'b1;
		end
	end

	// Counts the one-cycle event pulses that the fabric would route on.
	always @(posedge clk) begin
		if (cap_ev === 1'b1) n_cap++;
		if (ovf_ev === 1'b1) n_ovf++;
	end

	// Hang limit, well above the few hundred cycles the sequence needs.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("[FAIL] %0t run did not finish", $time);
			print_verdict();
		end
	end

	initial begin
		nrst = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		rd_pend = 1'b0;
		n_mismatch = 0;
		num_checks = 0;
		cyc = 0;
		n_cap = 0;
		n_ovf = 0;
		n = $urandom(13);
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		// Every register, and the unmapped word at 0x1c, reads zero after reset.
		for (int a = 0; a < 32; a += 4) rd(8'(a), 32'h0);
		sbet_fabric_model_i.set_port(1'(n));
		@(posedge clk);
		chk(pin, 1'(n));
		wr(sbet_pkg::ADDR_CONTROL_B, 32'h30);
		// The waveform flop takes the initial level one edge after the write lands.
		repeat (2) @(posedge clk);
		chk(pin, 1'b1);
		// Nothing counts while the enable bit is clear.
		wr(sbet_pkg::ADDR_COMPARE, 32'h5);
		sbet_fabric_model_i.ticks(2);
		rd(sbet_pkg::ADDR_COUNT, 32'h0);
		// Periodic mode clocked by the companion tick.
		wr(sbet_pkg::ADDR_CONTROL_B, 32'h0);
		wr(sbet_pkg::ADDR_CONTROL_A, ca(sbet_pkg::SRC_COMPANION));
		sbet_fabric_model_i.ticks(3);
		rd(sbet_pkg::ADDR_COUNT, 32'h3);
		sbet_fabric_model_i.ticks(3);
		rd(sbet_pkg::ADDR_COUNT, 32'h0);
		rd(sbet_pkg::ADDR_FLAGS, 32'h1);
		wr(sbet_pkg::ADDR_FLAGS, 32'h3);
		wr(sbet_pkg::ADDR_COUNT, 32'hfffd);
		sbet_fabric_model_i.ticks(3);
		rd(sbet_pkg::ADDR_COUNT, 32'h0);
		rd(sbet_pkg::ADDR_FLAGS, 32'h2);
		// Event channel as the counter clock.
		wr(sbet_pkg::ADDR_CONTROL_A, 32'h0);
		wr(sbet_pkg::ADDR_COUNT, 32'h0);
		wr(sbet_pkg::ADDR_CONTROL_A, ca(sbet_pkg::SRC_EVENT));
		repeat (3) begin
			sbet_fabric_model_i.level(1'b1);
			sbet_fabric_model_i.level(1'b0);
		end
		rd(sbet_pkg::ADDR_COUNT, 32'h3);
		// Divided system clock sources; the two mode codes beyond these run as periodic.
		wr(sbet_pkg::ADDR_COMPARE, 32'h100);
		for (int s = 0; s < 2; s++) begin
			wr(sbet_pkg::ADDR_CONTROL_B, 32'(3 + s));
			wr(sbet_pkg::ADDR_COUNT, 32'h0);
			wr(sbet_pkg::ADDR_CONTROL_A, ca(2'(s)));
			repeat (11) @(posedge clk);
			wr(sbet_pkg::ADDR_CONTROL_A, 32'h0);
			rd(sbet_pkg::ADDR_COUNT, (s == 0) ? 32'he : 32'h7);
		end
		// Capture on event; count cleared by a bus write on entry to the mode.
		wr(sbet_pkg::ADDR_CONTROL_A, 32'h0);
		wr(sbet_pkg::ADDR_CONTROL_B, {29'h0, sbet_pkg::MODE_CAP_EV});
		wr(sbet_pkg::ADDR_COUNT, 32'h0);
		wr(sbet_pkg::ADDR_FLAGS, 32'h3);
		wr(sbet_pkg::ADDR_CONTROL_A, ca(sbet_pkg::SRC_COMPANION));
		n = 1 + $urandom % 8;
		sbet_fabric_model_i.ticks(n);
		sbet_fabric_model_i.level(1'b1);
		sbet_fabric_model_i.ticks(2);
		sbet_fabric_model_i.level(1'b0);
		rd(sbet_pkg::ADDR_FLAGS, 32'h1);
		rd(sbet_pkg::ADDR_COMPARE, 32'(n));
		rd(sbet_pkg::ADDR_FLAGS, 32'h0);
		wr(sbet_pkg::ADDR_EVENT_CTL, 32'h10);
		sbet_fabric_model_i.level(1'b1);
		sbet_fabric_model_i.ticks(4);
		sbet_fabric_model_i.level(1'b0);
		rd(sbet_pkg::ADDR_COMPARE, 32'(n + 6));
		wr(sbet_pkg::ADDR_COUNT, 32'hfffe);
		sbet_fabric_model_i.ticks(2);
		rd(sbet_pkg::ADDR_FLAGS, 32'h2);
		rd(sbet_pkg::ADDR_COUNT, 32'h0);
		// Time-out check with each start and stop polarity.
		for (int e = 0; e < 2; e++) begin
			wr(sbet_pkg::ADDR_CONTROL_A, 32'h0);
			wr(sbet_pkg::ADDR_CONTROL_B, {29'h0, sbet_pkg::MODE_TIMEOUT});
			wr(sbet_pkg::ADDR_EVENT_CTL, 32'(e) << 4);
			wr(sbet_pkg::ADDR_COMPARE, 32'h2);
			wr(sbet_pkg::ADDR_FLAGS, 32'h3);
			wr(sbet_pkg::ADDR_CONTROL_A, ca(sbet_pkg::SRC_COMPANION));
			sbet_fabric_model_i.level(1'b1);
			if (e == 0) sbet_fabric_model_i.ticks(4);
			sbet_fabric_model_i.level(1'b0);
			if (e == 1) sbet_fabric_model_i.ticks(4);
			sbet_fabric_model_i.level(1'b1);
			sbet_fabric_model_i.level(1'b0);
			sbet_fabric_model_i.ticks(3);
			rd(sbet_pkg::ADDR_COUNT, 32'h4);
			rd(sbet_pkg::ADDR_FLAGS, 32'h1);
			rd(sbet_pkg::ADDR_COMPARE, 32'h2);
			wr(sbet_pkg::ADDR_STATUS, 32'h1);
			rd(sbet_pkg::ADDR_COUNT, 32'h4);
			rd(sbet_pkg::ADDR_FLAGS, 32'h1);
		end
		// A second reset in mid-run returns the registers to their values after reset.
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd(sbet_pkg::ADDR_COUNT, 32'h0);
		rd(sbet_pkg::ADDR_FLAGS, 32'h0);
		rd(sbet_pkg::ADDR_CONTROL_B, 32'h0);
		chk(n_cap, 32'h5);
		chk(n_ovf, 32'h2);
		repeat (2) @(posedge clk);
		print_verdict();
	end
endmodule : tb
`default_nettype wire
